// ---- ecppr_regs.sv ----
// Host register bank of an ECP capable parallel port with one shared FIFO.
// Assumes host strobes and port inputs are synchronous to sys_clk.
`timescale 1ns/1ps
// Function
// - Decode window by mode; offset 0 is latch or address FIFO; 1,2 in all but reserved mode; 402 always.
// - Offset 400 maps FIFO windows or capability word; 401 is resource report.
// - Every decode qualified by address enable; DMA cycles ignored.
// - Mode field encodes standard, bidir, FIFO, ECP, EPP, reserved, test, config.
// - Data latch clears on reset, loads on write strobe rise, drives lines.
// - Data port read at offset 0 returns sampled line levels.
// - ECP forward write at offset 0 enters FIFO tagged address, sent automatically.
// - Status bits 0 to 2 read zero.
// - Status bits 3-6 show live inputs; bit 7 shows inverted busy.
// - Reset clears control bits 0-5; bits 6,7 read zero, ignore writes.
// - Control bits 0,1,3 drive outputs inverted; bit 2 drives uninverted.
// - With ack enable set, rising ack edge raises port interrupt request.
// - Direction bit ignored in mode 000; in 010 it only picks the service flag threshold; else 0 out, 1 in.
// - Mode 010 FIFO bytes sent by automatic standard handshake, forward only.
// - ECP direction 0 sends FIFO bytes; direction 1 fills from peripheral.
// - Test mode FIFO read and written freely, no line handshake.
// - Test FIFO never stalls; full writes dropped, empty reads repeat last.
// - Test mode service flag sets at space or fill threshold by direction.
// - Test FIFO reads pop head in first-in first-out order.
// - Capability word at 400 in config mode reads constant 10H.
// - Resource report bit 7 reads zero; no hardware compression.
// - Resource bit 6 live irq level; 5:3 irq code; 2:0 dma code.
// - All FIFO windows share one sixteen entry tagged FIFO.
// - Mode field sits in extended control bits 7 to 5, read and write.
module ecppr_regs (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic [10:0] hostAddr,
  input  wire logic [7:0]  hostWrData,
  input  wire logic        ioWrite_b,
  input  wire logic        ioRead_b,
  input  wire logic        addrEnable,
  input  wire logic        eppEnable,
  input  wire logic [2:0]  irqCode,
  input  wire logic [2:0]  dmaCode,
  input  wire logic        irqLineLevel,
  output logic [7:0]       hostRdData,
  input  wire logic [7:0]  portDataLinesIn,
  output logic [7:0]       portDataLinesOut,
  output logic             portDataLinesOe,
  input  wire logic        peripheralErrorIn,
  input  wire logic        selectIn,
  input  wire logic        paperErrorIn,
  input  wire logic        peripheralAckIn,
  input  wire logic        busyIn,
  output logic             writePulseOut_b,
  output logic             hostAckOut_b,
  output logic             directionRequestOut,
  output logic             peripheralSelectOut_b,
  output logic             portIrqReq
);
  import ecppr_pkg::*;

  logic [7:0]  dataLatch_ff;
  logic [5:0]  ctrl_ff;
  logic [2:0]  mode_ff;
  logic [4:0]  extLow_ff;
  logic [8:0]  fifoMem [FIFO_DEPTH];
  logic [3:0]  wrPtr_ff;
  logic [3:0]  rdPtr_ff;
  logic [4:0]  count_ff;
  logic [7:0]  lastRd_ff;
  logic        wrDly_ff;
  logic        rdDly_ff;
  logic        ackDly_ff;
  logic        busyDly_ff;
  logic [4:0]  hsCnt_ff;
  ecppr_hs_t   hs_ff;
  logic [7:0]  txByte_ff;
  logic        txTag_ff;
  logic        fifoEmpty;
  logic        fifoFull;
  logic        wrStrobe;
  logic        rdStrobe;
  logic        dirIn;
  logic        hostPush;
  logic        hostPop;
  logic        linePush;
  logic        linePop;
  logic        doPush;
  logic        doPop;
  logic [8:0]  pushWord;
  logic [7:0]  nxt_rdData;
  logic [7:0]  statusWord;
  logic [2:0]  wrMode;

  // Offset decode shared by read and write paths
  function automatic logic hit(input logic [10:0] a, input logic [10:0] o);
    hit = (a == o);
  endfunction

  // Address enable high marks DMA cycles
  // dma cycles ignored
  assign wrStrobe = ~ioWrite_b & wrDly_ff & ~addrEnable;
  assign rdStrobe = ~ioRead_b & rdDly_ff & ~addrEnable;

  assign dirIn = ctrl_ff[CTL_DIR] &&
                 (mode_ff != MODE_STD) && (mode_ff != MODE_CFIF);
  assign fifoEmpty = (count_ff == 5'h00);
  assign fifoFull  = (count_ff == 5'(FIFO_DEPTH));

  always_comb begin
    hostPush = 1'b0;
    pushWord = {1'b0, hostWrData};
    if (wrStrobe) begin
      if (hit(hostAddr, OFS_DATA) && mode_ff == MODE_ECP && !dirIn) begin
        hostPush = 1'b1;
        pushWord = {1'b1, hostWrData};
      end else if (hit(hostAddr, OFS_FIFO) && (mode_ff == MODE_CFIF ||
                   mode_ff == MODE_TEST ||
                   (mode_ff == MODE_ECP && !dirIn))) begin
        hostPush = 1'b1;
      end
    end
    if (!hostPush && linePush) begin
      pushWord = {1'b0, portDataLinesIn};
    end
  end

  assign linePush = (mode_ff == MODE_ECP) && dirIn && ackDly_ff &&
                    ~peripheralAckIn && !fifoFull;
  assign hostPop = rdStrobe && hit(hostAddr, OFS_FIFO) &&
                   (mode_ff == MODE_TEST ||
                    (mode_ff == MODE_ECP && dirIn)) && !fifoEmpty;
  assign linePop = (hs_ff == HS_IDLE) && !fifoEmpty && !dirIn &&
                   !busyDly_ff && (mode_ff == MODE_CFIF || mode_ff == MODE_ECP);
  assign doPush = (hostPush || linePush) && !fifoFull;
  assign doPop  = hostPop || linePop;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrDly_ff   <= 1'b1;
      rdDly_ff   <= 1'b1;
      ackDly_ff  <= 1'b1;
      busyDly_ff <= 1'b0;
    end else begin
      wrDly_ff   <= ioWrite_b;
      rdDly_ff   <= ioRead_b;
      ackDly_ff  <= peripheralAckIn;
      busyDly_ff <= busyIn;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dataLatch_ff <= DATA_RST;
    end else if (ioWrite_b && !wrDly_ff && !addrEnable &&
                 hit(hostAddr, OFS_DATA) &&
                 (mode_ff == MODE_STD || mode_ff == MODE_BIDI)) begin
      dataLatch_ff <= hostWrData;
    end
  end

  // Latch loads on strobe release so data is settled; FIFO loads on fall
  // control write
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff <= CTRL_RST;
    end else if (wrStrobe && hit(hostAddr, OFS_CTRL) &&
                 mode_ff != MODE_RSV) begin
      ctrl_ff <= hostWrData[5:0];
    end
  end

  always_comb begin
    wrMode = hostWrData[7:EXT_MODE_LSB];
    if (wrMode == MODE_EPP && !eppEnable) begin
      wrMode = mode_ff;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_ff   <= MODE_STD;
      extLow_ff <= EXTC_RST;
    end else begin
      if (wrStrobe && hit(hostAddr, OFS_EXTC)) begin
        mode_ff   <= wrMode;
        extLow_ff <= hostWrData[4:0];
      end
      // Hardware set wins over a same-cycle software clear
      if (!extLow_ff[EXT_SVC] && !extLow_ff[EXT_DMAEN] &&
          ((!ctrl_ff[CTL_DIR] && (5'(FIFO_DEPTH) - count_ff) >=
            TX_SPACE_LEVEL) ||
           (ctrl_ff[CTL_DIR] && count_ff >= RX_FILL_LEVEL)) &&
          (mode_ff == MODE_TEST || mode_ff == MODE_ECP ||
           mode_ff == MODE_CFIF)) begin
        extLow_ff[EXT_SVC] <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (doPush) begin
      fifoMem[wrPtr_ff] <= pushWord;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_ff <= 4'h0;
      rdPtr_ff <= 4'h0;
      count_ff <= 5'h00;
    end else if (wrStrobe && hit(hostAddr, OFS_EXTC) &&
                 wrMode == MODE_STD) begin
      wrPtr_ff <= 4'h0;
      rdPtr_ff <= 4'h0;
      count_ff <= 5'h00;
    end else begin
      if (doPush) begin
        wrPtr_ff <= wrPtr_ff + 4'h1;
      end
      if (doPop) begin
        rdPtr_ff <= rdPtr_ff + 4'h1;
      end
      count_ff <= count_ff + 5'(doPush) - 5'(doPop);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hs_ff     <= HS_IDLE;
      hsCnt_ff  <= 5'h00;
      txByte_ff <= DATA_RST;
      txTag_ff  <= 1'b0;
    end else if (mode_ff != MODE_CFIF && mode_ff != MODE_ECP) begin
      hs_ff    <= HS_IDLE;
      hsCnt_ff <= 5'h00;
    end else begin
      case (hs_ff)
        HS_IDLE: begin
          if (linePop && !busyDly_ff) begin
            txByte_ff <= fifoMem[rdPtr_ff][7:0];
            txTag_ff  <= fifoMem[rdPtr_ff][8];
            hsCnt_ff  <= HS_CNT;
            hs_ff     <= HS_PULSE;
          end
        end
        HS_PULSE: begin
          if (hsCnt_ff == 5'h00) begin
            hs_ff <= HS_WAIT;
          end else begin
            hsCnt_ff <= hsCnt_ff - 5'h01;
          end
        end
        HS_WAIT: begin
          if (!busyDly_ff) begin
            hs_ff <= HS_IDLE;
          end
        end
        default: hs_ff <= HS_IDLE;
      endcase
    end
  end

  assign statusWord = {~busyIn, peripheralAckIn, paperErrorIn, selectIn,
                       peripheralErrorIn, 3'b000};

  always_comb begin
    nxt_rdData = 8'h00;
    if (mode_ff != MODE_RSV) begin
      if (hit(hostAddr, OFS_DATA) &&
          (mode_ff == MODE_STD || mode_ff == MODE_BIDI)) begin
        nxt_rdData = portDataLinesIn;
      end else if (hit(hostAddr, OFS_STAT)) begin
        nxt_rdData = statusWord;
      end else if (hit(hostAddr, OFS_CTRL)) begin
        nxt_rdData = {2'b00, ctrl_ff};
      end else if (hit(hostAddr, OFS_FIFO)) begin
        if (mode_ff == MODE_CFG) begin
          nxt_rdData = CAPABILITY_WORD;
        end else if (mode_ff == MODE_TEST ||
                     (mode_ff == MODE_ECP && dirIn)) begin
          nxt_rdData = fifoEmpty ? lastRd_ff : fifoMem[rdPtr_ff][7:0];
        end
      end else if (hit(hostAddr, OFS_RSRC) && mode_ff == MODE_CFG) begin
        nxt_rdData = {1'b0, irqLineLevel, irqCode, dmaCode};
      end
    end
    if (hit(hostAddr, OFS_EXTC)) begin
      nxt_rdData = {mode_ff, extLow_ff[4:2], fifoFull, fifoEmpty};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hostRdData <= 8'h00;
      lastRd_ff  <= 8'h00;
    end else if (rdStrobe) begin
      hostRdData <= nxt_rdData;
      if (hostPop) begin
        lastRd_ff <= fifoMem[rdPtr_ff][7:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      portDataLinesOut      <= 8'h00;
      portDataLinesOe       <= 1'b0;
      writePulseOut_b       <= 1'b1;
      hostAckOut_b          <= 1'b1;
      directionRequestOut   <= 1'b0;
      peripheralSelectOut_b <= 1'b1;
      portIrqReq            <= 1'b0;
    end else begin
      portDataLinesOe <= !dirIn;
      // Test mode shows the head byte; strobe follows control bit 0, not the FIFO
      if (mode_ff == MODE_CFIF || mode_ff == MODE_ECP) begin
        portDataLinesOut <= txByte_ff;
        writePulseOut_b  <= (hs_ff != HS_PULSE);
        hostAckOut_b     <= (mode_ff == MODE_ECP) ? ~txTag_ff : ~ctrl_ff[1];
      end else if (mode_ff == MODE_TEST) begin
        portDataLinesOut <= fifoMem[rdPtr_ff][7:0];
        writePulseOut_b  <= ~ctrl_ff[0];
        hostAckOut_b     <= ~ctrl_ff[1];
      end else begin
        portDataLinesOut <= dataLatch_ff;
        writePulseOut_b  <= ~ctrl_ff[0];
        hostAckOut_b     <= ~ctrl_ff[1];
      end
      directionRequestOut   <= ctrl_ff[2];
      peripheralSelectOut_b <= ~ctrl_ff[3];
      portIrqReq <= ctrl_ff[CTL_ACKIE] & ~ackDly_ff & peripheralAckIn;
    end
  end
endmodule

// ---- ecppr_pkg.sv ----
// Package for the parallel port host register bank.
// Assumes a single 25 MHz clock domain and byte-wide host accesses.
package ecppr_pkg;
  localparam logic [10:0] OFS_DATA = 11'h000;
  localparam logic [10:0] OFS_STAT = 11'h001;
  localparam logic [10:0] OFS_CTRL = 11'h002;
  localparam logic [10:0] OFS_FIFO = 11'h400;
  localparam logic [10:0] OFS_RSRC = 11'h401;
  localparam logic [10:0] OFS_EXTC = 11'h402;
  localparam logic [2:0] MODE_STD  = 3'h0;
  localparam logic [2:0] MODE_BIDI = 3'h1;
  localparam logic [2:0] MODE_CFIF = 3'h2;
  localparam logic [2:0] MODE_ECP  = 3'h3;
  localparam logic [2:0] MODE_EPP  = 3'h4;
  localparam logic [2:0] MODE_RSV  = 3'h5;
  localparam logic [2:0] MODE_TEST = 3'h6;
  localparam logic [2:0] MODE_CFG  = 3'h7;
  localparam int EXT_MODE_LSB = 5;
  localparam int EXT_ERRDIS   = 4;
  localparam int EXT_DMAEN    = 3;
  localparam int EXT_SVC      = 2;
  localparam int EXT_FULL     = 1;
  localparam int EXT_EMPTY    = 0;
  localparam int CTL_ACKIE    = 4;
  localparam int CTL_DIR      = 5;
  localparam logic [7:0] CAPABILITY_WORD = 8'h10;
  localparam logic [7:0] DATA_RST  = 8'h00;
  localparam logic [5:0] CTRL_RST  = 6'h00;
  localparam logic [4:0] EXTC_RST  = 5'h05;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW    = 4;
  localparam logic [4:0] TX_SPACE_LEVEL = 5'h08;
  localparam logic [4:0] RX_FILL_LEVEL  = 5'h08;
  localparam int HS_TIME_NS  = 500;
  localparam int CLK_PER_NS  = 40;
  localparam int HS_CYCLES   = (HS_TIME_NS + CLK_PER_NS - 1) / CLK_PER_NS;
  localparam logic [4:0] HS_CNT = 5'(HS_CYCLES);
  typedef enum logic [2:0] {
    HS_IDLE  = 3'b001,
    HS_PULSE = 3'b010,
    HS_WAIT  = 3'b100
  } ecppr_hs_t;
endpackage

// ---- ecppr_regs_properties.sv ----
// Assertions on host reads and port outputs of the parallel port register bank.
// Assumes a bind onto ecppr_regs; the mode is shadowed from host writes.
`timescale 1ns/1ps
module ecppr_regs_properties
  import ecppr_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic [10:0] hostAddr,
  input wire logic [7:0]  hostWrData,
  input wire logic        ioWrite_b,
  input wire logic        ioRead_b,
  input wire logic        addrEnable,
  input wire logic        eppEnable,
  input wire logic [2:0]  irqCode,
  input wire logic [2:0]  dmaCode,
  input wire logic        irqLineLevel,
  input wire logic [7:0]  hostRdData,
  input wire logic [7:0]  portDataLinesIn,
  input wire logic        portDataLinesOe,
  input wire logic        peripheralErrorIn,
  input wire logic        selectIn,
  input wire logic        paperErrorIn,
  input wire logic        peripheralAckIn,
  input wire logic        busyIn,
  input wire logic        peripheralSelectOut_b,
  input wire logic        directionRequestOut,
  input wire logic        portIrqReq
);
  logic       rdPrev_ff;
  logic       wrPrev_ff;
  logic [2:0] mode_ff;
  wire        rdFall = rdPrev_ff && !ioRead_b;
  wire        rdGo   = rdFall && !addrEnable;
  wire        wrGo   = wrPrev_ff && !ioWrite_b && !addrEnable;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdPrev_ff <= 1'h1;
      wrPrev_ff <= 1'h1;
    end else begin
      rdPrev_ff <= ioRead_b;
      wrPrev_ff <= ioWrite_b;
    end
  end
  // Shadow of the mode; a refused EPP request leaves it alone
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_ff <= MODE_STD;
    end else if (wrGo && hostAddr == OFS_EXTC &&
                 (hostWrData[7:5] != MODE_EPP || eppEnable)) begin
      mode_ff <= hostWrData[7:5];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  property p_statusRead;
    rdGo && hostAddr == OFS_STAT |=> hostRdData == {~$past(busyIn),
      $past(peripheralAckIn), $past(paperErrorIn), $past(selectIn),
      $past(peripheralErrorIn), 3'h0};
  endproperty
  a_statusRead: assert property (p_statusRead)
    else $error("status read mismatch");
  property p_dmaIgnored;
    rdFall && addrEnable |=> $stable(hostRdData);
  endproperty
  a_dmaIgnored: assert property (p_dmaIgnored)
    else $error("read during DMA cycle not ignored");
  property p_capWord;
    rdGo && hostAddr == OFS_FIFO && mode_ff == MODE_CFG
      |=> hostRdData == CAPABILITY_WORD;
  endproperty
  a_capWord: assert property (p_capWord)
    else $error("capability word wrong");
  property p_resource;
    rdGo && hostAddr == OFS_RSRC && mode_ff == MODE_CFG |=> hostRdData ==
      {1'h0, $past(irqLineLevel), $past(irqCode), $past(dmaCode)};
  endproperty
  a_resource: assert property (p_resource)
    else $error("resource report wrong");
  property p_modeRead;
    rdGo && hostAddr == OFS_EXTC |=> hostRdData[7:5] == $past(mode_ff);
  endproperty
  a_modeRead: assert property (p_modeRead)
    else $error("mode field read wrong");
  property p_reserved;
    rdGo && mode_ff == MODE_RSV &&
      (hostAddr == OFS_FIFO || hostAddr == OFS_RSRC) |=> hostRdData == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved mode read not zero");
  property p_bidiRead;
    rdGo && hostAddr == OFS_DATA && mode_ff == MODE_BIDI
      |=> hostRdData == $past(portDataLinesIn);
  endproperty
  a_bidiRead: assert property (p_bidiRead)
    else $error("data read not from lines");
  property p_stdDrive;
    (mode_ff == MODE_STD) [*3] |-> portDataLinesOe;
  endproperty
  a_stdDrive: assert property (p_stdDrive)
    else $error("standard mode not driving lines");
  property p_ctrlOut;
    logic [7:0] d;
    (wrGo && hostAddr == OFS_CTRL, d = hostWrData) |-> ##2
      (directionRequestOut == d[2] && peripheralSelectOut_b == !d[3]);
  endproperty
  a_ctrlOut: assert property (p_ctrlOut)
    else $error("control outputs do not follow write");
  property p_irqPulse;
    portIrqReq |=> !portIrqReq;
  endproperty
  a_irqPulse: assert property (p_irqPulse)
    else $error("interrupt request longer than one cycle");
  property p_irqCause;
    portIrqReq |-> $past(peripheralAckIn) && !$past(peripheralAckIn, 2);
  endproperty
  a_irqCause: assert property (p_irqCause)
    else $error("interrupt request without ack rise");
  c_testRead: cover property (rdGo && mode_ff == MODE_TEST);
  c_cfgRead: cover property (rdGo && mode_ff == MODE_CFG);
  c_irq: cover property (portIrqReq);
endmodule

// ---- ecppr_printer_model.sv ----
// Behavioural printer on the far side of the parallel lines.
// Assumes strobe and data come from the register bank on the same clock.
`timescale 1ns/1ps
module ecppr_printer_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       strobe_b,
  input  wire logic [7:0] linesOut,
  input  wire logic       linesOe,
  input  wire logic [7:0] periphByte,
  input  wire logic [4:0] busyHold,
  output logic            busy,
  output logic [7:0]      linesIn,
  output logic [7:0]      rxByte,
  output logic [7:0]      rxCount
);
  logic [4:0] holdCnt;
  // Released lines show the peripheral byte, never the stale host value
  assign linesIn = linesOe ? linesOut : periphByte;
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'h0;
      holdCnt <= 5'h00;
      rxCount <= 8'h00;
      rxByte <= 8'h00;
    end else if (!strobe_b && !busy) begin
      busy <= 1'h1;
      rxByte <= linesOut;
      rxCount <= rxCount + 8'h01;
      holdCnt <= busyHold;
    end else if (busy && strobe_b) begin
      // Interlocked: busy drops only after the strobe is released
      if (holdCnt == 5'h00) busy <= 1'h0;
      else holdCnt <= holdCnt - 5'h01;
    end
  end
endmodule

// ---- test_ecp_parallel_port_registers.sv ----
// Self-checking bench for the parallel port register bank.
// Assumes the printer model on the lines and one 25 MHz clock.
`timescale 1ns/1ps
module test_ecp_parallel_port_registers;
  import ecppr_pkg::*;
  logic sys_clk, rst_b, ioWrite_b, ioRead_b, addrEnable, eppEnable;
  logic irqLineLevel, portDataLinesOe, peripheralErrorIn, selectIn;
  logic paperErrorIn, peripheralAckIn, busyIn, writePulseOut_b;
  logic hostAckOut_b, directionRequestOut, peripheralSelectOut_b;
  logic portIrqReq;
  logic [10:0] hostAddr;
  logic [7:0]  hostWrData, hostRdData, portDataLinesIn, portDataLinesOut;
  logic [7:0]  periphByte, rxByte, rxCount;
  logic [2:0]  irqCode, dmaCode;
  int          n_fail, compares, nIrq, k;
  ecppr_regs u_dut (.*);
  ecppr_printer_model u_prn (.sys_clk(sys_clk), .rst_b(rst_b),
    .strobe_b(writePulseOut_b), .linesOut(portDataLinesOut),
    .linesOe(portDataLinesOe), .periphByte(periphByte), .busyHold(5'h03),
    .busy(busyIn), .linesIn(portDataLinesIn), .rxByte(rxByte),
    .rxCount(rxCount));
  initial begin
    sys_clk = 1'h0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (portIrqReq === 1'h1) nIrq++;
  task automatic chk(string n, logic [7:0] got, logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wr(logic [10:0] a, logic [7:0] d);
    @(posedge sys_clk);
    hostAddr <= a;
    hostWrData <= d;
    ioWrite_b <= 1'h0;
    repeat (2) @(posedge sys_clk);
    ioWrite_b <= 1'h1;
  endtask
  task automatic rc(string n, logic [10:0] a, logic [7:0] exp);
    @(posedge sys_clk);
    hostAddr <= a;
    ioRead_b <= 1'h0;
    repeat (2) @(posedge sys_clk);
    ioRead_b <= 1'h1;
    #1 chk(n, hostRdData, exp);
  endtask
  task automatic md(logic [2:0] m);
    wr(OFS_EXTC, {m, 5'h04});
  endtask
  task automatic lk(logic [10:0] a, logic [7:0] d);
    logic [7:0] c;
    c = rxCount;
    wr(a, d);
    for (k = 0; k < 200 && rxCount === c; k++) @(posedge sys_clk);
    chk("printer byte", rxByte, d);
  endtask
  task automatic tdone(string n);
    $display("test %s done", n);
  endtask
  task automatic finish_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #(40 * 20000);
    n_fail++;
    finish_test();
  end
  initial begin
    {rst_b, ioWrite_b, ioRead_b, addrEnable, eppEnable} = 5'h0C;
    {hostAddr, hostWrData, periphByte} = 27'h0;
    {irqLineLevel, irqCode, dmaCode} = 7'h5D;
    {peripheralAckIn, paperErrorIn, selectIn, peripheralErrorIn} = 4'h8;
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'h1;
    repeat (2) @(posedge sys_clk);
    rc("data", OFS_DATA, DATA_RST);
    rc("ctrl", OFS_CTRL, 8'h00);
    rc("extc", OFS_EXTC, {MODE_STD, EXTC_RST});
    wr(OFS_DATA, 8'hA5);
    repeat (2) @(posedge sys_clk);
    #1 chk("lines", portDataLinesOut, 8'hA5);
    @(posedge sys_clk) addrEnable <= 1'h1;
    wr(OFS_DATA, 8'h3C);
    @(posedge sys_clk) addrEnable <= 1'h0;
    rc("data", OFS_DATA, 8'hA5);
    @(posedge sys_clk) addrEnable <= 1'h1;
    rc("dma read", OFS_STAT, 8'hA5);
    @(posedge sys_clk) addrEnable <= 1'h0;
    tdone("data");
    wr(OFS_CTRL, 8'hFF);
    rc("ctrl", OFS_CTRL, 8'h3F);
    chk("pins", {4'h0, writePulseOut_b, hostAckOut_b, directionRequestOut,
      peripheralSelectOut_b}, 8'h02);
    wr(OFS_CTRL, 8'h10);
    // Let the printer drop busy so status bit 7 is settled
    repeat (8) @(posedge sys_clk);
    nIrq = 0;
    for (k = 0; k < 2; k++) begin
      @(posedge sys_clk);
      {peripheralAckIn, paperErrorIn, selectIn, peripheralErrorIn} <=
        k ? 4'hA : 4'h5;
      rc("status", OFS_STAT, k ? 8'hD0 : 8'hA8);
    end
    chk("irq count", 8'(nIrq), 8'h01);
    wr(OFS_CTRL, 8'h00);
    peripheralAckIn <= 1'h0;
    repeat (3) @(posedge sys_clk);
    peripheralAckIn <= 1'h1;
    repeat (3) @(posedge sys_clk);
    chk("irq masked", 8'(nIrq), 8'h01);
    tdone("control");
    md(MODE_BIDI);
    wr(OFS_CTRL, 8'h20);
    periphByte <= 8'h96;
    @(posedge sys_clk) #1 chk("oe bidi", 8'(portDataLinesOe), 8'h00);
    rc("bidi data", OFS_DATA, 8'h96);
    md(MODE_STD);
    @(posedge sys_clk) #1 chk("oe std", 8'(portDataLinesOe), 8'h01);
    wr(OFS_CTRL, 8'h00);
    tdone("direction");
    md(MODE_TEST);
    wr(OFS_FIFO, 8'h44);
    wr(OFS_FIFO, 8'h33);
    wr(OFS_FIFO, 8'h22);
    rc("extc", OFS_EXTC, {MODE_TEST, 5'h04});
    rc("head", OFS_FIFO, 8'h44);
    rc("next", OFS_FIFO, 8'h33);
    rc("last", OFS_FIFO, 8'h22);
    rc("reread", OFS_FIFO, 8'h22);
    rc("empty", OFS_EXTC, {MODE_TEST, 5'h05});
    for (int i = 0; i < 17; i++) wr(OFS_FIFO, 8'(i));
    rc("full", OFS_EXTC, {MODE_TEST, 5'h06});
    for (int i = 0; i < 16; i++) rc("fifo", OFS_FIFO, 8'(i));
    wr(OFS_FIFO, 8'h77);
    md(MODE_STD);
    md(MODE_TEST);
    rc("flushed", OFS_EXTC, {MODE_TEST, 5'h05});
    wr(OFS_EXTC, {MODE_TEST, 5'h00});
    rc("svc tx", OFS_EXTC, {MODE_TEST, 5'h05});
    wr(OFS_CTRL, 8'h20);
    wr(OFS_EXTC, {MODE_TEST, 5'h00});
    rc("svc rx idle", OFS_EXTC, {MODE_TEST, 5'h01});
    for (int i = 0; i < 8; i++) wr(OFS_FIFO, 8'(i));
    rc("svc rx", OFS_EXTC, {MODE_TEST, 5'h04});
    wr(OFS_CTRL, 8'h00);
    md(MODE_STD);
    tdone("fifo");
    md(MODE_CFG);
    wr(OFS_FIFO, 8'hFF);
    rc("capability", OFS_FIFO, CAPABILITY_WORD);
    rc("resource", OFS_RSRC, 8'h5D);
    md(MODE_STD);
    md(MODE_RSV);
    rc("rsv fifo", OFS_FIFO, 8'h00);
    rc("rsv resource", OFS_RSRC, 8'h00);
    md(MODE_STD);
    md(MODE_EPP);
    rc("epp refused", OFS_EXTC, {MODE_STD, 5'h05});
    eppEnable <= 1'h1;
    md(MODE_EPP);
    rc("epp taken", OFS_EXTC, {MODE_EPP, 5'h05});
    md(MODE_STD);
    tdone("modes");
    md(MODE_CFIF);
    lk(OFS_FIFO, 8'h5A);
    md(MODE_STD);
    md(MODE_ECP);
    lk(OFS_DATA, 8'h3C);
    chk("addr tag", 8'(hostAckOut_b), 8'h00);
    lk(OFS_FIFO, 8'hC3);
    chk("data tag", 8'(hostAckOut_b), 8'h01);
    md(MODE_STD);
    tdone("link");
    finish_test();
  end
endmodule
bind ecppr_regs ecppr_regs_properties u_chk (.*);
